// *** hdl/pc_reg_decode.sv ***
`timescale 1ns/1ps
module pc_reg_decode import pc_load_pkg::*; (
	input wire bus_req_t req,
	output logic selLow,
	output logic selLatch,
	output logic selTopLow,
	output logic selTopHigh,
	output logic selStatus,
	output logic selCount,
	output logic mapped
);
	assign selLow = req.addr == OFS_PC_LOW;
	assign selLatch = req.addr == OFS_UPPER_LATCH;
	assign selTopLow = req.addr == OFS_STACK_TOP_LOW;
	assign selTopHigh = req.addr == OFS_STACK_TOP_HIGH;
	assign selStatus = req.addr == OFS_LOAD_STATUS;
	assign selCount = req.addr == OFS_JUMP_COUNT;
	assign mapped = selLow | selLatch | selTopLow | selTopHigh |
		selStatus | selCount;
endmodule // pc_reg_decode

// *** hdl/pc_target_calc.sv ***
`timescale 1ns/1ps
module pc_target_calc import pc_load_pkg::*; (
	input wire logic [PC_W-1:0] pc,
	input wire logic [UP_W-1:0] upperLatch,
	input wire instr_t instr,
	output logic [PC_W-1:0] target,
	output logic jumps,
	output logic pushes
);
	wire logic [PC_W-1:0] callTarget;
	wire logic [PC_W-1:0] indirectTarget;
	wire logic [PC_W-1:0] unsignedTarget;
	wire logic [PC_W-1:0] signedTarget;

	assign callTarget = {upperLatch[6:3], instr.operand};
	assign indirectTarget = {upperLatch, instr.acc};
	// full-width add so the target may leave the 256 block
	assign unsignedTarget = relTarget(pc, {7'h00, instr.acc});
	assign signedTarget = relTarget(pc, signExt9(instr.operand[8:0]));

	always_comb begin
		target = pc + PC_STEP;
		jumps = 1'b1;
		pushes = 1'b0;
		unique case (instr.op)
			OP_NEXT: begin
				jumps = 1'b0;
			end
			OP_CALL: begin
				target = callTarget;
				pushes = 1'b1;
			end
			OP_CALL_INDIRECT: begin
				target = indirectTarget;
				pushes = 1'b1;
			end
			OP_JUMP_UNSIGNED: target = unsignedTarget;
			OP_JUMP_SIGNED: target = signedTarget;
			OP_VECTOR: begin
				target = VECTOR_ADDR;
				pushes = 1'b1;
			end
			default: begin
				jumps = 1'b0;
			end
		endcase
	end
endmodule // pc_target_calc

// *** hdl/program_counter_load_logic.sv ***
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module program_counter_load_logic import pc_load_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic softReset,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic instValid,
	input wire instr_t instr,
	output logic [PC_W-1:0] pcOut,
	output logic pushValid,
	output logic [PC_W-1:0] pushAddr
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// write strobe aimed at one register
	function automatic logic wrHit(input logic strobe, input logic sel);
		wrHit = strobe & sel;
	endfunction

	// next sequential address, also the return address of a call
	function automatic logic [PC_W-1:0] seqNext(input logic [PC_W-1:0] a);
		seqNext = a + PC_STEP;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] nxt_pc;
	logic [UP_W-1:0] upperLatch_ff;
	logic [UP_W-1:0] nxt_upperLatch;
	logic [PC_W-1:0] stackTop_ff;
	logic [PC_W-1:0] nxt_stackTop;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic pushValid_ff;
	logic nxt_pushValid;
	logic [PC_W-1:0] pushAddr_ff;
	logic [PC_W-1:0] nxt_pushAddr;
	src_t lastSrc_ff;
	src_t nxt_lastSrc;
	logic [7:0] jumpCount_ff;
	logic [7:0] nxt_jumpCount;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	bus_req_t req;
	logic selLow;
	logic selLatch;
	logic selTopLow;
	logic selTopHigh;
	logic selStatus;
	logic selCount;
	logic mapped;

	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	pc_reg_decode decode (
		.req(req),
		.selLow(selLow),
		.selLatch(selLatch),
		.selTopLow(selTopLow),
		.selTopHigh(selTopHigh),
		.selStatus(selStatus),
		.selCount(selCount),
		.mapped(mapped)
	);

	wire logic busLowWr;
	wire logic busLatchWr;
	wire logic busTopLowWr;
	wire logic busTopHighWr;

	assign busLowWr = wrHit(regWr, selLow);
	assign busLatchWr = wrHit(regWr, selLatch);
	assign busTopLowWr = wrHit(regWr, selTopLow);
	assign busTopHighWr = wrHit(regWr, selTopHigh);

	////////////////////////////////////////////////////////////////////////
	// instruction target

	logic [PC_W-1:0] instTarget;
	logic instJumps;
	logic instPushes;

	pc_target_calc calc (
		.pc(pc_ff),
		.upperLatch(upperLatch_ff),
		.instr(instr),
		.target(instTarget),
		.jumps(instJumps),
		.pushes(instPushes)
	);

	wire logic instLowWr;
	wire logic instTaken;
	wire logic anyLowWr;
	wire logic [7:0] lowWrData;
	wire logic doCall;
	wire logic doJump;
	wire logic doStep;
	wire logic [PC_W-1:0] lowWrTarget;
	wire logic [PC_W-1:0] returnAddr;

	// an instruction that targets the low byte is a load, not a branch
	assign instLowWr = instValid & instr.lowWrite;
	assign instTaken = instValid & ~instr.lowWrite;
	// a bus write to the low byte outranks the instruction in the same cycle
	assign anyLowWr = busLowWr | instLowWr;
	assign lowWrData = busLowWr ? regWdata : instr.lowData;
	assign lowWrTarget = {upperLatch_ff, lowWrData};
	assign doCall = instTaken & instPushes;
	assign doJump = instTaken & instJumps;
	// op codes 6 and 7 decode as a plain step
	assign doStep = instTaken & ~instJumps;
	// pc still holds the call's own address when the call is taken, so one step is added
	assign returnAddr = seqNext(pc_ff);

	wire logic pushTaken;

	// a call blocked by a bus low-byte write or a reset does not push
	assign pushTaken = doCall & ~busLowWr & ~softReset;

	////////////////////////////////////////////////////////////////////////
	// next counter value

	// the synchronous reset source beats every load
	always_comb begin
		nxt_pc = pc_ff;
		nxt_lastSrc = lastSrc_ff;
		if (softReset) begin
			nxt_pc = PC_RESET;
			nxt_lastSrc = SRC_RESET;
		end else if (anyLowWr) begin
			nxt_pc = lowWrTarget;
			nxt_lastSrc = SRC_LOW_WRITE;
		end else if (doJump) begin
			nxt_pc = instTarget;
			if (instr.op == OP_VECTOR) begin
				nxt_lastSrc = SRC_VECTOR;
			end else if (instPushes) begin
				nxt_lastSrc = SRC_CALL;
			end else begin
				nxt_lastSrc = SRC_BRANCH;
			end
		end else if (doStep) begin
			nxt_pc = seqNext(pc_ff);
			nxt_lastSrc = SRC_STEP;
		end
		// a latch write on its own falls through every branch above
	end

	////////////////////////////////////////////////////////////////////////
	// latch, stack top and push

	always_comb begin
		nxt_upperLatch = upperLatch_ff;
		if (softReset) begin
			nxt_upperLatch = LATCH_RESET;
		end else if (busLatchWr) begin
			nxt_upperLatch = regWdata[UP_W-1:0];
		end
		// pushes never touch the latch
	end

	wire logic [PC_W-1:0] topWritten;

	// a half written by software keeps the other half
	assign topWritten = {
		busTopHighWr ? regWdata[UP_W-1:0] : stackTop_ff[PC_W-1:8],
		busTopLowWr ? regWdata : stackTop_ff[7:0]
	};

	// a push outranks a software write to the stack top
	always_comb begin
		nxt_stackTop = topWritten;
		if (softReset) begin
			nxt_stackTop = STACK_TOP_RESET;
		end else if (pushTaken) begin
			nxt_stackTop = returnAddr;
		end
	end

	always_comb begin
		nxt_pushValid = 1'b0;
		nxt_pushAddr = pushAddr_ff;
		if (pushTaken) begin
			nxt_pushValid = 1'b1;
			nxt_pushAddr = returnAddr;
		end
	end

	wire logic countJump;

	assign countJump = (doJump & ~busLowWr) | anyLowWr;

	always_comb begin
		nxt_jumpCount = jumpCount_ff;
		if (softReset) begin
			nxt_jumpCount = COUNT_RESET;
		end else if (countJump) begin
			// wraps; software takes differences
			nxt_jumpCount = jumpCount_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, valid only in the cycle after the strobe

	wire logic [7:0] rdLow;
	wire logic [7:0] rdLatch;
	wire logic [7:0] rdTopLow;
	wire logic [7:0] rdTopHigh;
	wire logic [7:0] rdStatus;
	wire logic [7:0] rdCount;
	wire logic [7:0] readMux;
	wire logic readTaken;

	// upper counter bits have no read path of their own
	assign rdLow = pc_ff[7:0];
	assign rdLatch = {1'b0, upperLatch_ff};
	assign rdTopLow = stackTop_ff[7:0];
	assign rdTopHigh = {1'b0, stackTop_ff[PC_W-1:8]};
	assign rdStatus = {5'h00, lastSrc_ff};
	assign rdCount = jumpCount_ff;
	assign readTaken = regRd & mapped;

	assign readMux =
		selLow ? rdLow :
		selLatch ? rdLatch :
		selTopLow ? rdTopLow :
		selTopHigh ? rdTopHigh :
		selStatus ? rdStatus :
		selCount ? rdCount :
		8'h00;

	always_comb begin
		nxt_rdata = 8'h00;
		if (readTaken) begin
			nxt_rdata = readMux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flops

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pc_ff <= PC_RESET;
		end else if (clkEn) begin
			pc_ff <= nxt_pc;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lastSrc_ff <= SRC_RESET;
		end else if (clkEn) begin
			lastSrc_ff <= nxt_lastSrc;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			upperLatch_ff <= LATCH_RESET;
		end else if (clkEn) begin
			upperLatch_ff <= nxt_upperLatch;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stackTop_ff <= STACK_TOP_RESET;
		end else if (clkEn) begin
			stackTop_ff <= nxt_stackTop;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pushValid_ff <= 1'b0;
		end else if (clkEn) begin
			pushValid_ff <= nxt_pushValid;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pushAddr_ff <= STACK_TOP_RESET;
		end else if (clkEn) begin
			pushAddr_ff <= nxt_pushAddr;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else if (clkEn) begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			jumpCount_ff <= COUNT_RESET;
		end else if (clkEn) begin
			jumpCount_ff <= nxt_jumpCount;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign regRdata = rdata_ff;
	assign pcOut = pc_ff;
	assign pushValid = pushValid_ff;
	assign pushAddr = pushAddr_ff;

endmodule // program_counter_load_logic

// *** pkg/pc_load_pkg.sv ***
package pc_load_pkg;

	localparam int PC_W = 15;
	localparam int UP_W = 7;

	// register indices, also the port addresses
	localparam logic [2:0] OFS_PC_LOW = 3'h0;
	localparam logic [2:0] OFS_UPPER_LATCH = 3'h1;
	localparam logic [2:0] OFS_STACK_TOP_LOW = 3'h2;
	localparam logic [2:0] OFS_STACK_TOP_HIGH = 3'h3;
	localparam logic [2:0] OFS_LOAD_STATUS = 3'h4;
	localparam logic [2:0] OFS_JUMP_COUNT = 3'h5;

	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	localparam logic [UP_W-1:0] LATCH_RESET = 7'h00;
	localparam logic [PC_W-1:0] STACK_TOP_RESET = 15'h0000;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

	typedef enum logic [2:0] {
		OP_NEXT = 3'b000,
		OP_CALL = 3'b001,
		OP_CALL_INDIRECT = 3'b010,
		OP_JUMP_UNSIGNED = 3'b011,
		OP_JUMP_SIGNED = 3'b100,
		OP_VECTOR = 3'b101
	} op_t;

	typedef enum logic [2:0] {
		SRC_RESET = 3'b000,
		SRC_STEP = 3'b001,
		SRC_LOW_WRITE = 3'b010,
		SRC_CALL = 3'b011,
		SRC_BRANCH = 3'b100,
		SRC_VECTOR = 3'b101
	} src_t;

	typedef struct packed {
		op_t op;
		logic [10:0] operand;
		logic [7:0] acc;
		logic lowWrite;
		logic [7:0] lowData;
	} instr_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	function automatic logic [PC_W-1:0] relTarget(
		input logic [PC_W-1:0] base,
		input logic [PC_W-1:0] offset
	);
		relTarget = base + PC_STEP + offset;
	endfunction

	function automatic logic [PC_W-1:0] signExt9(input logic [8:0] v);
		signExt9 = {{(PC_W-9){v[8]}}, v};
	endfunction

endpackage

// *** sim/program_counter_load_logic_asserts.sv ***
`timescale 1ns/1ps
module program_counter_load_logic_asserts import pc_load_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic softReset,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic instValid,
	input wire instr_t instr,
	input wire logic [PC_W-1:0] pcOut,
	input wire logic pushValid,
	input wire logic [PC_W-1:0] pushAddr
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
// bus low-byte write beats the instruction
wire busLow = regWr && regAddr == OFS_PC_LOW;
wire go = clkEn && instValid && !instr.lowWrite && !busLow && !softReset;
wire isCall = instr.op == OP_CALL || instr.op == OP_CALL_INDIRECT;
wire [PC_W-1:0] seqAddr = pcOut + PC_STEP;
wire [PC_W-1:0] sOfs = {{6{instr.operand[8]}}, instr.operand[8:0]};
////////////////////////////////////////////////////////////////////////
a_soft_clear: assert property (
	clkEn && softReset |=> pcOut == PC_RESET) else $error("pc not cleared");
a_low_load: assert property (
	clkEn && busLow && !softReset |=> pcOut[7:0] == $past(regWdata))
	else $error("low write lost");
a_freeze: assert property (
	!clkEn || !(instValid || softReset || busLow) |=> $stable(pcOut))
	else $error("pc moved without cause");
a_step: assert property (
	go && instr.op == OP_NEXT |=> pcOut == $past(seqAddr))
	else $error("step wrong");
a_call_addr: assert property (
	go && instr.op == OP_CALL |=> pcOut[10:0] == $past(instr.operand))
	else $error("call target wrong");
a_call_push: assert property (
	go && isCall |=> pushValid && pushAddr == $past(seqAddr))
	else $error("call push wrong");
a_indirect: assert property (
	go && instr.op == OP_CALL_INDIRECT |=> pcOut[7:0] == $past(instr.acc))
	else $error("indirect target wrong");
a_jump_u: assert property (
	go && instr.op == OP_JUMP_UNSIGNED
	|=> pcOut == $past(seqAddr) + $past(instr.acc)) else $error("jump u");
a_jump_s: assert property (
	go && instr.op == OP_JUMP_SIGNED
	|=> pcOut == $past(seqAddr) + $past(sOfs)) else $error("jump s");
a_push_pulse: assert property (
	clkEn && !instValid |=> !pushValid) else $error("stray push");
a_read_low: assert property (
	clkEn && regRd && regAddr == OFS_PC_LOW && !softReset
	|=> regRdata == $past(pcOut[7:0])) else $error("low read wrong");
c_call: cover property (go && instr.op == OP_CALL);
c_jump: cover property (go && instr.op == OP_JUMP_SIGNED);
c_low: cover property (clkEn && busLow);
endmodule // program_counter_load_logic_asserts

// *** sim/tb_program_counter_load_logic.sv ***
`timescale 1ns/1ps
module tb_program_counter_load_logic import pc_load_pkg::*;;
logic clk = 0, reset = 1, clkEn = 1, softReset = 0;
logic [2:0] regAddr = 3'h0;
logic [7:0] regWdata = 8'h00, regRdata, d;
logic regWr = 0, regRd = 0, instValid = 0, pushValid;
instr_t instr = '0;
logic [PC_W-1:0] pcOut, pushAddr, pc, ret;
logic [UP_W-1:0] lat = 7'h2d;
int numErrors = 0, nChecks = 0;
always #5 clk = ~clk;
program_counter_load_logic dut (.clk(clk), .reset(reset), .clkEn(clkEn),
	.softReset(softReset), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.instValid(instValid), .instr(instr), .pcOut(pcOut),
	.pushValid(pushValid), .pushAddr(pushAddr));
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [PC_W-1:0] g, e);
	nChecks++;
	if (g !== e) begin
		numErrors++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task automatic wr(input logic [2:0] a, input logic [7:0] v);
	@(posedge clk);
	regWr <= 1;
	regAddr <= a;
	regWdata <= v;
	@(posedge clk);
	regWr <= 0;
	@(negedge clk);
endtask
task automatic rd(input logic [2:0] a);
	@(posedge clk);
	regRd <= 1;
	regAddr <= a;
	@(posedge clk);
	regRd <= 0;
	@(negedge clk);
	d = regRdata;
endtask
task automatic ex(input op_t o, input logic [10:0] opd, input logic [7:0] ac);
	@(posedge clk);
	instValid <= 1;
	instr <= '{o, opd, ac, 1'b0, 8'h00};
	@(posedge clk);
	instValid <= 0;
	@(negedge clk);
endtask
task automatic exLow(input logic [7:0] v);
	@(posedge clk);
	instValid <= 1;
	instr <= '{OP_CALL, 11'h000, 8'h00, 1'b1, v};
	@(posedge clk);
	instValid <= 0;
	@(negedge clk);
endtask
task automatic wrap_up;
	if (numErrors == 0 && nChecks > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	#20000;
	numErrors++;
	wrap_up();
end
initial begin
	repeat (5) @(posedge clk);
	reset <= 0;
	@(negedge clk);
	chk(pcOut, PC_RESET);
	wr(OFS_UPPER_LATCH, {1'b0, lat});
	chk(pcOut, PC_RESET);
	wr(OFS_PC_LOW, 8'hf0);
	pc = {lat, 8'hf0};
	chk(pcOut, pc);
	rd(OFS_PC_LOW);
	chk(d, 8'hf0);
	ex(OP_NEXT, 11'h000, 8'h00);
	pc = pc + PC_STEP;
	chk(pcOut, pc);
	// carry must leave the 256 block
	ex(OP_JUMP_UNSIGNED, 11'h000, 8'hff);
	pc = pc + PC_STEP + 15'h00ff;
	chk(pcOut, pc);
	// a 9-bit offset with bit 8 set must be sign-extended
	ex(OP_JUMP_SIGNED, 11'h1f0, 8'h00);
	pc = pc + PC_STEP + 15'h7ff0;
	chk(pcOut, pc);
	ret = pc + PC_STEP;
	ex(OP_CALL, 11'h123, 8'h00);
	pc = {lat[6:3], 11'h123};
	chk(pcOut, pc);
	chk(pushValid, 1'b1);
	chk(pushAddr, ret);
	ret = pc + PC_STEP;
	ex(OP_CALL_INDIRECT, 11'h000, 8'h5a);
	pc = {lat, 8'h5a};
	chk(pcOut, pc);
	chk(pushAddr, ret);
	rd(OFS_STACK_TOP_LOW);
	chk(d, ret[7:0]);
	rd(OFS_UPPER_LATCH);
	chk(d, {1'b0, lat});
	wr(OFS_STACK_TOP_HIGH, 8'h15);
	rd(OFS_STACK_TOP_HIGH);
	chk(d, 8'h15);
	rd(3'h7);
	chk(d, 8'h00);
	// table past the block: software moves the latch first
	lat = 7'h2e;
	wr(OFS_UPPER_LATCH, {1'b0, lat});
	exLow(8'h08);
	chk(pcOut, {lat, 8'h08});
	chk(pushValid, 1'b0);
	ex(OP_VECTOR, 11'h000, 8'h00);
	chk(pushValid, 1'b1);
	chk(pcOut, VECTOR_ADDR);
	pc = VECTOR_ADDR;
	// a frozen core must ignore the fetch
	@(posedge clk) clkEn <= 0;
	ex(OP_NEXT, 11'h000, 8'h00);
	chk(pcOut, pc);
	@(posedge clk) clkEn <= 1;
	// seven loads so far: low write, two jumps, two calls, low load, vector
	rd(OFS_JUMP_COUNT);
	chk(d, 8'h07);
	rd(OFS_LOAD_STATUS);
	chk(d, {5'h00, SRC_VECTOR});
	@(posedge clk) softReset <= 1;
	@(posedge clk) softReset <= 0;
	@(negedge clk);
	chk(pcOut, PC_RESET);
	rd(OFS_JUMP_COUNT);
	chk(d, COUNT_RESET);
	wrap_up();
end
endmodule // tb_program_counter_load_logic
bind program_counter_load_logic program_counter_load_logic_asserts u_chk (
	.clk(clk), .reset(reset), .clkEn(clkEn), .softReset(softReset),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .instValid(instValid), .instr(instr),
	.pcOut(pcOut), .pushValid(pushValid), .pushAddr(pushAddr));
